// File: sweep_setpoint_map.vh
// constants for the sweep setpoint generator
`ifndef SWEEP_SETPOINT_MAP_VH
`define SWEEP_SETPOINT_MAP_VH
// sweep modes (i_sweep_mode)
`define SWP_MODE_OFF     2'h0
`define SWP_MODE_LINEAR  2'h1
`define SWP_MODE_LOG     2'h2
// point count limits
`define SWP_MAX_POINTS   16'hffff
`define SWP_MIN_LOG_STEP 16'h0002
// zero offset limit: 110.000 V in millivolt units
`define ZERO_OFS_LIMIT   32'sd110000
// limiter during zero: 0.5 % of range = range * 5 / 1000
`define ZERO_LIM_NUM     5
`define ZERO_LIM_DEN     1000
// fractional bits of the log ratio
`define LOG_FRAC_BITS    16
// calibration slots, one per range
`define CAL_RANGE_BITS   3
`endif

// File: cal_offset_store.v
// per-range offset calibration store, registered read
`timescale 1ns/1ps
`default_nettype none
`include "sweep_setpoint_map.vh"
module cal_offset_store #(
    parameter AW = `CAL_RANGE_BITS,
    parameter DW = 32
) (
    // clock and reset
    input  wire          i_core_clk,
    input  wire          i_rst_n,
    // write port
    input  wire          i_wr,
    input  wire [AW-1:0] i_wr_range,
    input  wire [DW-1:0] i_wr_data,
    // read port
    input  wire [AW-1:0] i_rd_range,
    output reg  [DW-1:0] o_rd_data
);
    reg [DW-1:0] mem_r [0:(1<<AW)-1];
    genvar g;
    // reset clears every slot, so a power cycle drops all results
    generate
        for (g = 0; g < (1<<AW); g = g + 1) begin : g_slot
            always @(posedge i_core_clk) begin
                if (!i_rst_n)
                    mem_r[g] <= {DW{1'b0}};
                else if (i_wr && i_wr_range == g)
                    mem_r[g] <= i_wr_data;
            end
        end
    endgenerate
    // registered read data
    always @(posedge i_core_clk) begin
        if (!i_rst_n)
            o_rd_data <= {DW{1'b0}};
        else
            o_rd_data <= mem_r[i_rd_range];
    end
endmodule // cal_offset_store
`default_nettype wire

// File: source_sweep_setpoint_gen.v
// sweep and zero setpoint generator for a source-measure output stage
// Functional notes
// - linear sweep adds a fixed step per point from start toward stop.
// - linear point count above 65535 flags error, sweep limited to 65535.
// - log sweep moves start to stop geometrically over configured steps.
// - log step count accepted only from 2 to 65535.
// - log start and stop of opposite sign flag error, no sweep.
// - log start or stop of zero flags error, no sweep.
// - zero generation drives zero volts or zero amps.
// - zero generation adds the zero offset to the zero level.
// - zero offset accepted only within plus and minus 110.000 V.
// - zero offset beyond the selected range is clamped to its limits.
// - low-z zero on voltage, high-z on current: zero source, limiter kept.
// - other zero impedance cases: zero source, limiter at 0.5 % of range.
// - offset calibration applies only to the range it was run on.
// - calibration results are cleared on power up.
// - sweep off holds the level while cycles continue.
`timescale 1ns/1ps
`default_nettype none
`include "sweep_setpoint_map.vh"
module source_sweep_setpoint_gen #(
    parameter DW = 32,
    parameter RW = `CAL_RANGE_BITS
) (
    // clock and reset
    input  wire          i_core_clk,
    input  wire          i_rst_n,
    // sweep setup
    input  wire [1:0]    i_sweep_mode,
    input  wire [DW-1:0] i_sweep_start,
    input  wire [DW-1:0] i_sweep_stop,
    input  wire [DW-1:0] i_sweep_step,
    input  wire [15:0]   i_log_step_count,
    input  wire [DW-1:0] i_log_ratio,
    input  wire          i_sweep_begin,
    input  wire          i_cycle_start,
    // dc level when not sweeping; limiter level used whether sweeping or not
    input  wire [DW-1:0] i_dc_level,
    input  wire [DW-1:0] i_limiter_level,
    // zero generation
    input  wire          i_zero_en,
    input  wire          i_zero_hiz,
    input  wire          i_source_is_current,
    input  wire [DW-1:0] i_zero_offset,
    input  wire          i_zero_offset_wr,
    // range and calibration
    input  wire [RW-1:0] i_range_sel,
    input  wire [DW-1:0] i_range_span,
    input  wire          i_offset_cal_execute,
    input  wire [DW-1:0] i_cal_measured_offset,
    // setpoint to analog stage
    output reg  [DW-1:0] o_setpoint,
    output reg  [DW-1:0] o_limiter,
    output reg  [15:0]   o_point_index,
    output reg           o_sweep_active,
    // errors
    output reg           o_err_lin_points,
    output reg           o_err_log_count,
    output reg           o_err_log_sign,
    output reg           o_err_log_zero,
    output reg           o_err_zero_offset
);
    localparam ST_IDLE  = 3'b001;
    localparam ST_RUN   = 3'b010;
    localparam ST_DONE  = 3'b100;
    localparam FB       = `LOG_FRAC_BITS;

    reg  [2:0]         state_r;
    reg  [2:0]         state_nxt;
    reg  signed [DW-1:0] level_r;
    reg  [15:0]        idx_r;
    reg  [15:0]        last_idx_r;
    reg  signed [DW-1:0] zofs_r;
    reg  [1:0]         mode_r;
    wire [DW-1:0]      cal_ofs;

    // absolute value, used for both span and step
    function [DW-1:0] absval;
        input [DW-1:0] v;
        begin
            absval = v[DW-1] ? (~v + {{(DW-1){1'b0}}, 1'b1}) : v;
        end
    endfunction

    // linear point count; wide so overflow past 65535 is visible.
    // a zero step gives one point, never an all-ones last index
    wire [DW-1:0] lin_span  = absval(i_sweep_stop - i_sweep_start);
    wire [DW-1:0] lin_stepa = absval(i_sweep_step);
    wire [DW-1:0] lin_pts   = (lin_stepa == {DW{1'b0}}) ? {{(DW-1){1'b0}}, 1'b1} :
                              lin_span / lin_stepa + {{(DW-1){1'b0}}, 1'b1};
    wire          lin_over  = lin_pts > {{(DW-16){1'b0}}, `SWP_MAX_POINTS};
    wire [15:0]   lin_last  = lin_over ? 16'hfffe : lin_pts[15:0] - 16'h0001;

    // log sweep validity checks
    wire log_cnt_bad  = i_log_step_count < `SWP_MIN_LOG_STEP;
    wire log_zero_bad = (i_sweep_start == {DW{1'b0}}) ||
                        (i_sweep_stop == {DW{1'b0}});
    wire log_sign_bad = i_sweep_start[DW-1] ^ i_sweep_stop[DW-1];
    wire log_refuse   = log_cnt_bad | log_zero_bad | log_sign_bad;

    // zero offset range check and clamp to the selected range span
    wire signed [DW-1:0] zin   = i_zero_offset;
    wire signed [DW-1:0] span  = i_range_span;
    wire                 z_ok  = (zin <= `ZERO_OFS_LIMIT) &&
                                 (zin >= -`ZERO_OFS_LIMIT);
    wire signed [DW-1:0] zclmp = (zofs_r > span) ? span :
                                 (zofs_r < -span) ? -span : zofs_r;

    // log multiply: level * ratio in fixed point, ratio supplied by software
    wire signed [2*DW-1:0] log_prod = level_r * $signed(i_log_ratio);
    wire signed [DW-1:0]   log_next = log_prod[FB+DW-1:FB];

    // calibration store, one slot per range, cleared by reset
    cal_offset_store #(.AW(RW), .DW(DW)) u_cal (
        .i_core_clk (i_core_clk),
        .i_rst_n    (i_rst_n),
        .i_wr       (i_offset_cal_execute),
        .i_wr_range (i_range_sel),
        .i_wr_data  (i_cal_measured_offset),
        .i_rd_range (i_range_sel),
        .o_rd_data  (cal_ofs)
    );

    // sweep state transitions
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (i_sweep_begin && mode_r == `SWP_MODE_LINEAR)
                    state_nxt = ST_RUN;
                else if (i_sweep_begin && mode_r == `SWP_MODE_LOG && !log_refuse)
                    state_nxt = ST_RUN;
            end
            ST_RUN: begin
                if (mode_r == `SWP_MODE_OFF)
                    state_nxt = ST_IDLE;
                else if (i_cycle_start && idx_r == last_idx_r)
                    state_nxt = ST_DONE;
            end
            // a linear or accepted log begin after the last point re-arms at once, in step with the datapath
            ST_DONE: begin
                if (mode_r == `SWP_MODE_OFF)
                    state_nxt = ST_IDLE;
                else if (i_sweep_begin && (mode_r == `SWP_MODE_LINEAR ||
                         (mode_r == `SWP_MODE_LOG && !log_refuse)))
                    state_nxt = ST_RUN;
                else if (i_sweep_begin)
                    state_nxt = ST_IDLE;
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // sweep datapath; a linear or accepted log begin outside ST_RUN restarts from the first point, a begin during ST_RUN is ignored
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            state_r    <= ST_IDLE;
            level_r    <= {DW{1'b0}};
            idx_r      <= 16'h0000;
            last_idx_r <= 16'h0000;
            mode_r     <= `SWP_MODE_OFF;
        end else begin
            state_r <= state_nxt;
            mode_r  <= i_sweep_mode;
            if (i_sweep_begin && state_r != ST_RUN &&
                (mode_r == `SWP_MODE_LINEAR ||
                 (mode_r == `SWP_MODE_LOG && !log_refuse))) begin
                level_r    <= i_sweep_start;
                idx_r      <= 16'h0000;
                last_idx_r <= (mode_r == `SWP_MODE_LOG) ?
                              i_log_step_count - 16'h0001 : lin_last;
            end else if (state_r == ST_RUN && i_cycle_start &&
                         idx_r != last_idx_r) begin
                idx_r <= idx_r + 16'h0001;
                if (mode_r == `SWP_MODE_LOG)
                    level_r <= log_next;
                else
                    level_r <= level_r + $signed(i_sweep_step);
            end
        end
    end

    // zero offset register keeps the last accepted value
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            zofs_r            <= {DW{1'b0}};
            o_err_zero_offset <= 1'b0;
        end else if (i_zero_offset_wr) begin
            o_err_zero_offset <= !z_ok;
            if (z_ok)
                zofs_r <= zin;
        end
    end

    // error flags follow the setup, latched at each begin request
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_err_lin_points <= 1'b0;
            o_err_log_count  <= 1'b0;
            o_err_log_sign   <= 1'b0;
            o_err_log_zero   <= 1'b0;
        end else if (i_sweep_begin) begin
            o_err_lin_points <= (mode_r == `SWP_MODE_LINEAR) && lin_over;
            o_err_log_count  <= (mode_r == `SWP_MODE_LOG) && log_cnt_bad;
            o_err_log_sign   <= (mode_r == `SWP_MODE_LOG) && log_sign_bad;
            o_err_log_zero   <= (mode_r == `SWP_MODE_LOG) && log_zero_bad;
        end
    end

    // output selection: zero wins over sweep, sweep over dc level.
    // the limiter product is done here once; range span is small enough
    // that span*5 never overflows the data width in practice
    always @(posedge i_core_clk) begin
        if (!i_rst_n) begin
            o_setpoint     <= {DW{1'b0}};
            o_limiter      <= {DW{1'b0}};
            o_point_index  <= 16'h0000;
            o_sweep_active <= 1'b0;
        end else begin
            o_point_index  <= idx_r;
            o_sweep_active <= (state_r == ST_RUN);
            if (i_zero_en) begin
                o_setpoint <= zclmp + $signed(cal_ofs);
                if (i_zero_hiz ^ i_source_is_current)
                    o_limiter <= (i_range_span * `ZERO_LIM_NUM) /
                                 `ZERO_LIM_DEN;
                else
                    o_limiter <= i_limiter_level;
            end else begin
                o_limiter <= i_limiter_level;
                if (state_r == ST_IDLE || mode_r == `SWP_MODE_OFF)
                    o_setpoint <= i_dc_level + cal_ofs;
                else
                    o_setpoint <= level_r + cal_ofs;
            end
        end
    end
endmodule // source_sweep_setpoint_gen
`default_nettype wire

// File: source_sweep_setpoint_gen_sva.sv
// assertions for the sweep and zero setpoint generator
`timescale 1ns/1ps
`default_nettype none
`include "sweep_setpoint_map.vh"
module source_sweep_setpoint_gen_sva (
    // clock and reset
    input wire logic        i_core_clk,
    input wire logic        i_rst_n,
    // stimulus
    input wire logic [1:0]  i_sweep_mode,
    input wire logic [31:0] i_sweep_start,
    input wire logic [31:0] i_sweep_stop,
    input wire logic [15:0] i_log_step_count,
    input wire logic        i_sweep_begin,
    input wire logic        i_cycle_start,
    input wire logic        i_zero_en,
    input wire logic        i_zero_hiz,
    input wire logic        i_source_is_current,
    input wire logic [31:0] i_zero_offset,
    input wire logic        i_zero_offset_wr,
    input wire logic [31:0] i_limiter_level,
    input wire logic [31:0] i_range_span,
    // outputs
    input wire logic [31:0] o_limiter,
    input wire logic [15:0] o_point_index,
    input wire logic        o_sweep_active,
    input wire logic        o_err_log_count,
    input wire logic        o_err_log_sign,
    input wire logic        o_err_log_zero,
    input wire logic        o_err_zero_offset
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);
    // begin from idle with the lagging mode register already settled
    sequence s_log_begin;
        i_sweep_begin && !o_sweep_active && i_sweep_mode == `SWP_MODE_LOG && $stable(i_sweep_mode);
    endsequence
    sequence s_zero_low;
        (i_zero_en && (i_zero_hiz ^ i_source_is_current) && $stable(i_range_span)) [*3];
    endsequence
    sequence s_zero_keep;
        (i_zero_en && !(i_zero_hiz ^ i_source_is_current) && $stable(i_limiter_level)) [*3];
    endsequence
    property p_log_count;
        s_log_begin ##0 (i_log_step_count < `SWP_MIN_LOG_STEP) |=> (o_err_log_count && !o_sweep_active) [*2];
    endproperty
    property p_log_sign;
        s_log_begin ##0 (i_sweep_start[31] != i_sweep_stop[31] && i_sweep_start != 0 && i_sweep_stop != 0)
            |=> o_err_log_sign && !o_sweep_active;
    endproperty
    property p_log_zero;
        s_log_begin ##0 (i_sweep_start == 0 || i_sweep_stop == 0) |=> o_err_log_zero ##1 !o_sweep_active;
    endproperty
    property p_log_ok;
        s_log_begin ##0 (i_log_step_count >= `SWP_MIN_LOG_STEP && i_sweep_start != 0 && i_sweep_stop != 0
            && i_sweep_start[31] == i_sweep_stop[31]) |=> ##[0:2] o_sweep_active;
    endproperty
    property p_ofs_err;
        i_zero_offset_wr |=> o_err_zero_offset == ($signed($past(i_zero_offset)) > `ZERO_OFS_LIMIT
            || $signed($past(i_zero_offset)) < -`ZERO_OFS_LIMIT);
    endproperty
    property p_zero_lim;
        s_zero_low |-> o_limiter == (i_range_span * 32'd5) / 32'd1000;
    endproperty
    property p_zero_keep;
        s_zero_keep |-> o_limiter == i_limiter_level;
    endproperty
    // the index may only move on a cycle start or a fresh arm
    property p_idx_hold;
        (!i_cycle_start && !i_sweep_begin && $stable(i_sweep_mode)) [*2] |=> $stable(o_point_index);
    endproperty
    a_log_count: assert property (p_log_count) else $error("log count not refused");
    a_log_sign: assert property (p_log_sign) else $error("log sign not refused");
    a_log_zero: assert property (p_log_zero) else $error("log zero not refused");
    a_log_ok: assert property (p_log_ok) else $error("valid log sweep not started");
    a_ofs_err: assert property (p_ofs_err) else $error("zero offset flag wrong");
    a_zero_lim: assert property (p_zero_lim) else $error("zero limiter not set");
    a_zero_keep: assert property (p_zero_keep) else $error("zero limiter changed");
    a_idx_hold: assert property (p_idx_hold) else $error("index moved without cycle");
endmodule // source_sweep_setpoint_gen_sva
bind source_sweep_setpoint_gen source_sweep_setpoint_gen_sva u_source_sweep_setpoint_gen_sva (.*);
`default_nettype wire

// File: analog_stage_model.sv
// analog source stage stand-in watching the setpoint generator
`timescale 1ns/1ps
`default_nettype none
module analog_stage_model (
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst_n,
    // setpoint side
    input  wire logic       i_sweep_active,
    input  wire logic [2:0] i_range_sel,
    // set once the range moved during a sweep
    output var  logic       o_range_moved
);
    logic [2:0] range_r;
    // a range change mid-sweep makes the level jump, so it is latched for the bench
    always @(posedge i_core_clk) begin
        range_r <= i_range_sel;
        if (!i_rst_n) o_range_moved <= 1'b0;
        else if (i_sweep_active && range_r != i_range_sel) o_range_moved <= 1'b1;
    end
endmodule // analog_stage_model
`default_nettype wire

// File: test_source_sweep_setpoint_gen.sv
// self-checking bench for the sweep and zero setpoint generator
`timescale 1ns/1ps
`default_nettype none
`include "sweep_setpoint_map.vh"
module test_source_sweep_setpoint_gen;
    logic        i_core_clk, i_rst_n, i_sweep_begin, i_cycle_start, i_zero_en, i_zero_hiz;
    logic        i_source_is_current, i_zero_offset_wr, i_offset_cal_execute, range_moved;
    logic        o_sweep_active, o_err_lin_points, o_err_log_count, o_err_log_sign;
    logic        o_err_log_zero, o_err_zero_offset;
    logic [1:0]  i_sweep_mode;
    logic [2:0]  i_range_sel;
    logic [15:0] i_log_step_count, o_point_index;
    logic [31:0] i_sweep_start, i_sweep_stop, i_sweep_step, i_log_ratio, i_dc_level, o_limiter;
    logic [31:0] i_limiter_level, i_zero_offset, i_range_span, i_cal_measured_offset, o_setpoint;
    int          mismatches = 0, total_checks = 0;
    logic [15:0] cnt [4] = '{16'h1, 16'h4, 16'h4, 16'hffff};
    logic [31:0] sta [4] = '{32'h64, 32'hffffff9c, 32'h0, 32'h64};
    logic [3:0]  exf [4] = '{4'h8, 4'h4, 4'h2, 4'h1};
    source_sweep_setpoint_gen u_source_sweep_setpoint_gen (.*);
    analog_stage_model u_analog_stage_model (.i_core_clk, .i_rst_n, .i_sweep_active(o_sweep_active),
        .i_range_sel, .o_range_moved(range_moved));
    always #20 i_core_clk = ~i_core_clk;
    task automatic wt(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one pulse, then let the two-stage output settle
    task automatic cyc;
        i_cycle_start = 1'b1;
        wt(1);
        i_cycle_start = 1'b0;
        wt(3);
    endtask
    // mode goes one cycle ahead of begin because the design registers it
    task automatic arm(input logic [1:0] m);
        i_sweep_mode = m;
        wt(1);
        i_sweep_begin = 1'b1;
        wt(1);
        i_sweep_begin = 1'b0;
        wt(4);
    endtask
    task automatic ofs(input logic [31:0] v);
        i_zero_offset = v;
        i_zero_offset_wr = 1'b1;
        wt(1);
        i_zero_offset_wr = 1'b0;
        wt(4);
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // the run needs about 66000 cycles; give up at 90000
    initial begin
        #3600000;
        mismatches++;
        complete_run;
    end
    initial begin
        {i_core_clk, i_rst_n, i_sweep_begin, i_cycle_start, i_zero_en, i_zero_hiz} = '0;
        {i_source_is_current, i_zero_offset_wr, i_offset_cal_execute, i_sweep_mode, i_range_sel} = '0;
        {i_sweep_start, i_sweep_stop, i_sweep_step} = {32'h64, 32'h8c, 32'ha};
        {i_log_step_count, i_log_ratio, i_dc_level, i_limiter_level} = {16'h4, 32'h20000, 64'h309};
        {i_zero_offset, i_range_span, i_cal_measured_offset} = {32'h0, 32'h2710, 32'h7};
        wt(2);
        i_rst_n = 1'b1;
        arm(`SWP_MODE_LINEAR);
        chk({o_err_lin_points, o_sweep_active}, 32'h1);
        for (int k = 0; k < 6; k++) begin
            chk(o_setpoint, 32'h64 + 32'ha * (k < 4 ? k : 4));
            if (k < 5) chk(o_point_index, k < 4 ? k : 4);
            cyc;
        end
        {i_sweep_start, i_sweep_stop, i_sweep_step} = {32'h0, 32'h11170, 32'h1};
        arm(`SWP_MODE_LINEAR);
        chk(o_err_lin_points, 32'h1);
        i_cycle_start = 1'b1;
        wt(65540);
        i_cycle_start = 1'b0;
        wt(3);
        chk({o_point_index, o_setpoint[15:0]}, 32'hfffefffe);
        {i_sweep_start, i_sweep_stop} = {32'h64, 32'h320};
        arm(`SWP_MODE_LOG);
        for (int k = 0; k < 5; k++) begin
            chk(o_setpoint, 32'h64 << (k < 3 ? k : 3));
            cyc;
        end
        for (int k = 0; k < 4; k++) begin
            {i_log_step_count, i_sweep_start} = {cnt[k], sta[k]};
            arm(`SWP_MODE_LOG);
            chk({o_err_log_count, o_err_log_sign, o_err_log_zero, o_sweep_active}, exf[k]);
        end
        i_sweep_mode = `SWP_MODE_OFF;
        i_dc_level = 32'h4d2;
        wt(3);
        cyc;
        cyc;
        chk({o_setpoint, o_sweep_active}, 33'h9a4);
        i_zero_en = 1'b1;
        ofs(32'h0);
        chk(o_setpoint, 32'h0);
        ofs(32'h1388);
        for (int k = 0; k < 4; k++) begin
            {i_zero_hiz, i_source_is_current} = k[1:0];
            wt(4);
            chk(o_setpoint, 32'h1388);
            chk(o_limiter, (k == 1 || k == 2) ? 32'h32 : 32'h309);
        end
        ofs(32'h4e20);
        chk(o_setpoint, 32'h2710);
        ofs(32'hffffb1e0);
        chk(o_setpoint, 32'hffffd8f0);
        ofs(32'h1d4c0);
        chk({o_err_zero_offset, o_setpoint}, 33'h1ffffd8f0);
        ofs(32'h1adb0);
        chk({o_err_zero_offset, o_setpoint}, 33'h2710);
        i_range_sel = 3'h1;
        i_offset_cal_execute = 1'b1;
        wt(1);
        i_offset_cal_execute = 1'b0;
        wt(4);
        chk(o_setpoint, 32'h2717);
        i_range_sel = 3'h2;
        wt(4);
        chk(o_setpoint, 32'h2710);
        i_rst_n = 1'b0;
        wt(2);
        i_rst_n = 1'b1;
        i_range_sel = 3'h1;
        ofs(32'h64);
        chk(o_setpoint, 32'h64);
        chk(range_moved, 32'h0);
        complete_run;
    end
endmodule // test_source_sweep_setpoint_gen
`default_nettype wire
